// file: rtl/rst_clk_pkg.sv
// Package for the reset-source combiner and clock-source selector.
// Assumes a single 100 MHz core clock and plain control ports.
package rst_clk_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int          WDOG_W           = 32;
  localparam int          SRC_W            = 2;
  localparam int          SRC2_W           = 3;
  localparam int          VOLT_ADJ_W       = 6;
  localparam logic [5:0]  VOLT_ADJ_RESET   = 6'h00;
  localparam logic [1:0]  OSC_SRC_RESET    = 2'h1;
  localparam logic [2:0]  OSC_SRC2_RESET   = 3'h0;
  localparam logic [7:0]  SYS_RESET_CYCLES = 8'h10;

  // ==========================================================
  // Clock source encodings
  localparam logic [1:0]  SRC_MAIN         = 2'h0;
  localparam logic [1:0]  SRC_INT          = 2'h1;
  localparam logic [1:0]  SRC_INT_DIV4     = 2'h2;
  localparam logic [1:0]  SRC_SLOW30K      = 2'h3;
  localparam logic [2:0]  SRC2_RTC         = 3'h7;

  // Selected system clock source
  typedef enum logic [2:0] {
    CLK_INT, CLK_INT_DIV4, CLK_MAIN, CLK_SLOW30K, CLK_RTC, CLK_PLL
  } clk_sel_t;

  // Reset cause flags
  typedef struct packed {
    logic watchdog;
    logic software;
    logic brownout;
    logic poweron;
    logic external;
  } reset_cause_t;

  // Core boot fetch phases after internal reset release
  typedef enum logic [1:0] {
    BOOT_FETCH_SP, BOOT_FETCH_PC, BOOT_FETCH_INSN, BOOT_RUN
  } boot_phase_t;

endpackage

// file: rtl/reset_source_and_clock_select.sv
// Reset combiner, watchdog, reset-cause store and clock selector.
// Assumes all inputs are synchronous to core_clk and software sits
// behind the plain control ports.
`timescale 1ns/100ps
module reset_source_and_clock_select
  import rst_clk_pkg::*;
#(
  parameter int NUM_PERIPH = 32,
  parameter int NUM_DOMAIN = 2
) (
  // Clock and power-on reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Reset requests
  input  wire logic                    ext_reset_n,
  input  wire logic                    brownout_detect,
  input  wire logic                    brownout_reset_enable,
  input  wire logic                    system_reset_request_bit,
  input  wire logic [NUM_PERIPH-1:0]   peripheral_soft_reset_registers,
  // Watchdog control
  input  wire logic [WDOG_W-1:0]       watchdog_load_value,
  input  wire logic                    wdog_enable,
  input  wire logic                    wdog_reset_enable,
  input  wire logic                    wdog_int_clear,
  // Regulator and clock control
  input  wire logic [VOLT_ADJ_W-1:0]   regulator_voltage_adjust,
  input  wire logic                    clk_cfg_write,
  input  wire logic                    pll_bypass,
  input  wire logic [SRC_W-1:0]        oscillator_source_select,
  input  wire logic [SRC2_W-1:0]       extended_oscillator_source_select,
  input  wire logic                    use_extended_source,
  // Reset and status outputs
  output logic                         sys_reset,
  output logic [NUM_PERIPH*NUM_DOMAIN-1:0] periph_reset,
  output logic                         brownout_irq,
  output logic                         wdog_irq,
  output reset_cause_t                 reset_cause_register,
  output boot_phase_t                  boot_phase,
  // Clock and regulator outputs
  output clk_sel_t                     system_clock_select,
  output logic                         pll_ref_main,
  output logic [VOLT_ADJ_W-1:0]        regulator_power_control
);

  // ==========================================================
  // Reset request combining
  logic [7:0]              hold_cnt_reg;
  logic [7:0]              hold_cnt_next;
  logic                    sys_reset_reg;
  logic                    swreq_prev_reg;
  logic [WDOG_W-1:0]       wdog_cnt_reg;
  logic                    wdog_int_reg;
  logic                    wdog_rst_reg;
  logic                    wdog_zero;
  logic                    brownout_rst_req;
  logic                    sw_rst_req;
  logic                    any_rst_req;

  // Brown-out only resets when enabled; else it interrupts
  assign brownout_rst_req = brownout_detect & brownout_reset_enable;
  assign sw_rst_req   = system_reset_request_bit & ~swreq_prev_reg;
  assign any_rst_req  = ~ext_reset_n | brownout_rst_req | sw_rst_req | wdog_rst_reg;
  assign wdog_zero    = (wdog_cnt_reg == '0);

  // Level requests hold reset; pulse requests stretch it
  assign hold_cnt_next = any_rst_req ? SYS_RESET_CYCLES :
                         (hold_cnt_reg != 8'h00) ? hold_cnt_reg - 8'h01 : 8'h00;

  // Internal system reset sequencing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt_reg   <= SYS_RESET_CYCLES;
      sys_reset_reg  <= 1'b1;
      swreq_prev_reg <= 1'b0;
    end else begin
      hold_cnt_reg   <= hold_cnt_next;
      sys_reset_reg  <= any_rst_req | (hold_cnt_next != 8'h00);
      swreq_prev_reg <= system_reset_request_bit;
    end
  end
  assign sys_reset = sys_reset_reg;

  // Brown-out interrupt when reset is not selected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      brownout_irq <= 1'b0;
    end else begin
      brownout_irq <= brownout_detect & ~brownout_reset_enable;
    end
  end

  // ==========================================================
  // Watchdog, two-stage time-out
  always_ff @(posedge core_clk) begin
    if (rst || sys_reset_reg) begin
      wdog_cnt_reg <= '1;
      wdog_int_reg <= 1'b0;
      wdog_rst_reg <= 1'b0;
    end else if (!wdog_enable) begin
      wdog_cnt_reg <= watchdog_load_value;
      wdog_int_reg <= wdog_int_reg & ~wdog_int_clear;
      wdog_rst_reg <= 1'b0;
    end else if (wdog_zero) begin
      wdog_cnt_reg <= watchdog_load_value;
      // Set wins over a clear in the same cycle
      wdog_int_reg <= 1'b1;
      wdog_rst_reg <= wdog_int_reg & wdog_reset_enable;
    end else begin
      wdog_cnt_reg <= wdog_cnt_reg - 1'b1;
      wdog_int_reg <= wdog_int_reg & ~wdog_int_clear;
      wdog_rst_reg <= 1'b0;
    end
  end
  assign wdog_irq = wdog_int_reg;

  // ==========================================================
  // Reset cause store, every flag sticky until power-on reset
  reset_cause_t cause_next;
  assign cause_next = '{watchdog: reset_cause_register.watchdog | wdog_rst_reg,
                        software: reset_cause_register.software | sw_rst_req,
                        brownout: reset_cause_register.brownout | brownout_rst_req,
                        poweron:  reset_cause_register.poweron,
                        external: reset_cause_register.external | ~ext_reset_n};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_cause_register <= '{poweron: 1'b1, default: 1'b0};
    end else begin
      reset_cause_register <= cause_next;
    end
  end

  // ==========================================================
  // Peripheral software resets, one bit per peripheral
  logic [NUM_PERIPH-1:0] periph_bit_prev_reg;
  logic [NUM_PERIPH-1:0] periph_fire;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      periph_bit_prev_reg <= '0;
    end else begin
      periph_bit_prev_reg <= peripheral_soft_reset_registers;
    end
  end

  // Falling edge of a set bit fires the peripheral reset
  assign periph_fire = periph_bit_prev_reg & ~peripheral_soft_reset_registers;

  // Bit index equals the clock gating bit index of the unit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge core_clk) begin
        if (rst) begin
          periph_reset[gi*NUM_DOMAIN +: NUM_DOMAIN] <= '1;
        end else begin
          // Every domain reset of the unit together
          periph_reset[gi*NUM_DOMAIN +: NUM_DOMAIN] <=
            {NUM_DOMAIN{periph_fire[gi] | peripheral_soft_reset_registers[gi] |
                        sys_reset_reg}};
        end
      end
    end
  endgenerate

  // ==========================================================
  // Core boot fetch sequence after reset release
  always_ff @(posedge core_clk) begin
    if (rst || sys_reset_reg) begin
      boot_phase <= BOOT_FETCH_SP;
    end else begin
      case (boot_phase)
        BOOT_FETCH_SP:   boot_phase <= BOOT_FETCH_PC;
        BOOT_FETCH_PC:   boot_phase <= BOOT_FETCH_INSN;
        BOOT_FETCH_INSN: boot_phase <= BOOT_RUN;
        BOOT_RUN:        boot_phase <= BOOT_RUN;
        default:         boot_phase <= BOOT_FETCH_SP;
      endcase
    end
  end

  // ==========================================================
  // System clock source selection
  clk_sel_t clk_sel_next;
  logic     pll_ref_next;

  // Bypass picks a raw source; otherwise the main-fed PLL if main is selected, else the internal oscillator
  always_comb begin
    clk_sel_next = CLK_PLL;
    pll_ref_next = 1'b0;
    if (pll_bypass) begin
      if (use_extended_source && extended_oscillator_source_select == SRC2_RTC) begin
        clk_sel_next = CLK_RTC;
      end else begin
        case (oscillator_source_select)
          SRC_MAIN:     clk_sel_next = CLK_MAIN;
          SRC_INT:      clk_sel_next = CLK_INT;
          SRC_INT_DIV4: clk_sel_next = CLK_INT_DIV4;
          SRC_SLOW30K:  clk_sel_next = CLK_SLOW30K;
          default:      clk_sel_next = CLK_INT;
        endcase
      end
    end else if (oscillator_source_select == SRC_MAIN) begin
      pll_ref_next = 1'b1;
    end else begin
      clk_sel_next = CLK_INT;
    end
  end

  // Internal oscillator until software writes a new choice
  always_ff @(posedge core_clk) begin
    if (rst) begin
      system_clock_select     <= CLK_INT;
      pll_ref_main            <= 1'b0;
      regulator_power_control <= VOLT_ADJ_RESET;
    end else begin
      if (clk_cfg_write) begin
        system_clock_select <= clk_sel_next;
        pll_ref_main        <= pll_ref_next;
      end
      regulator_power_control <= regulator_voltage_adjust;
    end
  end

  // ==========================================================
  // Checks
  brownout_holds_a: assert property (@(posedge core_clk) disable iff (rst)
    brownout_rst_req |=> sys_reset)
    else $error("brown-out did not hold reset");
  brownout_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (brownout_detect && !brownout_reset_enable) |=> brownout_irq)
    else $error("brown-out interrupt missing");
  brownout_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    brownout_rst_req |=> reset_cause_register.brownout)
    else $error("brown-out cause not recorded");
  sw_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    sw_rst_req |=> sys_reset [*8])
    else $error("software reset too short");
  wdog_reload_a: assert property (@(posedge core_clk) disable iff (rst)
    (wdog_enable && wdog_zero && !sys_reset) |=>
      wdog_irq && wdog_cnt_reg == $past(watchdog_load_value))
    else $error("watchdog reload wrong");
  wdog_second_a: assert property (@(posedge core_clk) disable iff (rst)
    (wdog_enable && wdog_zero && wdog_irq && wdog_reset_enable && !sys_reset)
      |=> ##1 sys_reset)
    else $error("watchdog second time-out no reset");
  periph_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(peripheral_soft_reset_registers[0]) |=> periph_reset[0] && periph_reset[1])
    else $error("peripheral reset missing");
  boot_order_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sys_reset) |-> boot_phase == BOOT_FETCH_SP ##1 boot_phase == BOOT_FETCH_PC
      ##1 boot_phase == BOOT_FETCH_INSN ##1 boot_phase == BOOT_RUN)
    else $error("boot fetch order wrong");
  rtc_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    (clk_cfg_write && pll_bypass && use_extended_source &&
     extended_oscillator_source_select == SRC2_RTC) |=> system_clock_select == CLK_RTC)
    else $error("RTC not selected");

endmodule

// file: tb/tb_reset_source_and_clock_select.sv
// Self-checking bench for the reset combiner and clock selector.
// Assumes rst_clk_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module tb_reset_source_and_clock_select
  import rst_clk_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic                 core_clk, rst, ext_reset_n, brownout_detect, brownout_reset_enable;
  logic                 system_reset_request_bit, wdog_enable, wdog_reset_enable;
  logic                 wdog_int_clear, clk_cfg_write, pll_bypass, use_extended_source;
  logic [31:0]          peripheral_soft_reset_registers;
  logic [WDOG_W-1:0]    watchdog_load_value;
  logic [VOLT_ADJ_W-1:0] regulator_voltage_adjust, regulator_power_control;
  logic [SRC_W-1:0]     oscillator_source_select;
  logic [SRC2_W-1:0]    extended_oscillator_source_select;
  logic                 sys_reset, brownout_irq, wdog_irq, pll_ref_main;
  logic [63:0]          periph_reset;
  reset_cause_t         reset_cause_register;
  boot_phase_t          boot_phase;
  clk_sel_t             system_clock_select;
  int                   fails = 0;
  int                   cmp_count = 0;
  int                   cycles = 0;

  reset_source_and_clock_select reset_source_and_clock_select_inst (
    .core_clk(core_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .brownout_detect(brownout_detect), .brownout_reset_enable(brownout_reset_enable),
    .system_reset_request_bit(system_reset_request_bit),
    .peripheral_soft_reset_registers(peripheral_soft_reset_registers),
    .watchdog_load_value(watchdog_load_value), .wdog_enable(wdog_enable),
    .wdog_reset_enable(wdog_reset_enable), .wdog_int_clear(wdog_int_clear),
    .regulator_voltage_adjust(regulator_voltage_adjust), .clk_cfg_write(clk_cfg_write),
    .pll_bypass(pll_bypass), .oscillator_source_select(oscillator_source_select),
    .extended_oscillator_source_select(extended_oscillator_source_select),
    .use_extended_source(use_extended_source), .sys_reset(sys_reset),
    .periph_reset(periph_reset), .brownout_irq(brownout_irq), .wdog_irq(wdog_irq),
    .reset_cause_register(reset_cause_register), .boot_phase(boot_phase),
    .system_clock_select(system_clock_select), .pll_ref_main(pll_ref_main),
    .regulator_power_control(regulator_power_control)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Wait for internal reset release, then follow the boot fetch order
  task automatic wait_boot(output int held);
    held = 0;
    while (sys_reset !== 1'b0 && held < 200) begin
      tick();
      held++;
    end
    check("boot_sp", boot_phase, BOOT_FETCH_SP);
    tick();
    check("boot_pc", boot_phase, BOOT_FETCH_PC);
    tick();
    check("boot_insn", boot_phase, BOOT_FETCH_INSN);
    tick();
    check("boot_run", boot_phase, BOOT_RUN);
  endtask

  // ==========================================================
  // Scenarios
  task automatic por_test();
    int held;
    rst = 1'b1;
    tick(5);
    check("por_sys", sys_reset, 1'b1);
    check("por_periph", periph_reset, '1);
    check("por_cause", reset_cause_register, 5'h02);
    check("por_clk", system_clock_select, CLK_INT);
    check("por_irq", {brownout_irq, wdog_irq, pll_ref_main}, 3'h0);
    rst = 1'b0;
    wait_boot(held);
    check("post_clk", system_clock_select, CLK_INT);
  endtask

  task automatic brownout_test();
    int held;
    brownout_detect = 1'b1;
    tick(2);
    check("bo_irq", brownout_irq, 1'b1);
    check("bo_no_reset", sys_reset, 1'b0);
    brownout_detect = 1'b0;
    tick(2);
    check("bo_irq_off", brownout_irq, 1'b0);
    brownout_reset_enable = 1'b1;
    brownout_detect = 1'b1;
    tick(30);
    check("bo_held", sys_reset, 1'b1);
    check("bo_cause", reset_cause_register, 5'h06);
    brownout_detect = 1'b0;
    wait_boot(held);
    brownout_reset_enable = 1'b0;
  endtask

  task automatic sw_ext_test();
    int held;
    system_reset_request_bit = 1'b1;
    tick();
    check("sw_reset", sys_reset, 1'b1);
    check("sw_cause", reset_cause_register, 5'h0E);
    system_reset_request_bit = 1'b0;
    wait_boot(held);
    check("sw_hold", held, SYS_RESET_CYCLES);
    ext_reset_n = 1'b0;
    tick(3);
    check("ext_reset", sys_reset, 1'b1);
    check("ext_cause", reset_cause_register, 5'h0F);
    ext_reset_n = 1'b1;
    wait_boot(held);
  endtask

  task automatic periph_test();
    peripheral_soft_reset_registers = 32'h8000_0021;
    tick();
    check("periph_on", periph_reset, 64'hC000_0000_0000_0C03);
    check("periph_core", sys_reset, 1'b0);
    peripheral_soft_reset_registers = 32'h0000_0000;
    tick();
    check("periph_pulse", periph_reset, 64'hC000_0000_0000_0C03);
    tick(2);
    check("periph_off", periph_reset, 64'h0);
  endtask

  task automatic sel_clk(input logic byp, input logic [1:0] src, input logic [2:0] src2,
                         input logic ext, input clk_sel_t exp, input logic pll);
    pll_bypass = byp;
    oscillator_source_select = src;
    extended_oscillator_source_select = src2;
    use_extended_source = ext;
    clk_cfg_write = 1'b1;
    tick();
    clk_cfg_write = 1'b0;
    check("clk_sel", system_clock_select, exp);
    check("pll_ref", pll_ref_main, pll);
    tick();
  endtask

  task automatic wdog_test();
    int n;
    int held;
    wdog_reset_enable = 1'b1;
    wdog_enable = 1'b1;
    n = 0;
    while (wdog_irq !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    check("wd_irq", wdog_irq, 1'b1);
    check("wd_first", n >= 15 && n <= 25, 1'b1);
    wdog_int_clear = 1'b1;
    tick();
    wdog_int_clear = 1'b0;
    check("wd_clear", wdog_irq, 1'b0);
    n = 0;
    while (wdog_irq !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    check("wd_reload", n >= 15 && n <= 25, 1'b1);
    check("wd_no_reset", sys_reset, 1'b0);
    n = 0;
    while (sys_reset !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    wdog_enable = 1'b0;
    check("wd_second", n >= 15 && n <= 25, 1'b1);
    check("wd_cause", reset_cause_register, 5'h1F);
    wait_boot(held);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst, brownout_detect, brownout_reset_enable, system_reset_request_bit} = 4'h8;
    {wdog_enable, wdog_reset_enable, wdog_int_clear, clk_cfg_write} = 4'h0;
    {pll_bypass, use_extended_source} = 2'h0;
    ext_reset_n = 1'b1;
    peripheral_soft_reset_registers = 32'h0000_0000;
    watchdog_load_value = 32'h0000_0014;
    regulator_voltage_adjust = 6'h00;
    oscillator_source_select = SRC_INT;
    extended_oscillator_source_select = 3'h0;
    por_test();
    brownout_test();
    sw_ext_test();
    periph_test();
    // Main oscillator taken as enabled and settled before this switch
    sel_clk(1'b1, SRC_MAIN, 3'h0, 1'b0, CLK_MAIN, 1'b0);
    sel_clk(1'b1, SRC_INT, 3'h0, 1'b0, CLK_INT, 1'b0);
    sel_clk(1'b1, SRC_INT_DIV4, 3'h0, 1'b0, CLK_INT_DIV4, 1'b0);
    sel_clk(1'b1, SRC_SLOW30K, 3'h0, 1'b0, CLK_SLOW30K, 1'b0);
    sel_clk(1'b1, SRC_INT, SRC2_RTC, 1'b1, CLK_RTC, 1'b0);
    sel_clk(1'b0, SRC_MAIN, 3'h0, 1'b0, CLK_PLL, 1'b1);
    sel_clk(1'b0, SRC_INT, 3'h0, 1'b0, CLK_INT, 1'b0);
    for (int i = 0; i <= VOLT_ADJ_W; i++) begin
      regulator_voltage_adjust = 6'h3F >> i;
      tick();
      check("reg_adjust", regulator_power_control, 6'h3F >> i);
    end
    wdog_test();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    check("por_clears", reset_cause_register, 5'h02);
    wrap_up();
  end
endmodule
